/* design/cmc_defines.svh */
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CMC_OFF_CTRL_ONE  4'h0
`define CMC_OFF_CTRL_TWO  4'h1
`define CMC_OFF_CFG_TWO   4'h2
`define CMC_OFF_DATA_BIT_COMPARE_COUNT_SET 4'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define CMC_BIT_IDLE_STOP 13
`define CMC_BIT_ABORT     12
`define CMC_REQ_HI        10
`define CMC_REQ_LO        8
`define CMC_CUR_HI        7
`define CMC_CUR_LO        5
`define CMC_BIT_CAPTURE   3
`define CMC_BIT_WINDOW    0
`define CMC_BIT_WAKE_FILT 14
// ----------------------------------------
// codes and counts
// ----------------------------------------
`define CMC_MODE_NORMAL   3'h0
`define CMC_MODE_DISABLE  3'h1
`define CMC_MODE_LOOPBACK 3'h2
`define CMC_MODE_LISTEN   3'h3
`define CMC_MODE_CONFIG   3'h4
`define CMC_MODE_RSVD5    3'h5
`define CMC_MODE_RSVD6    3'h6
`define CMC_MODE_ALL      3'h7
`define CMC_MODE_RESET    3'h4
`define CMC_IDLE_BITS     11
`define CMC_DATA_BIT_COMPARE_COUNT_MAX     5'h11
`define CMC_BASE_ID_W     11
`define CMC_EXT_ID_W      18
`define CMC_MAX_OVERLOAD  2
`define CMC_WAKE_TAPS     4
`endif

/* design/cmc_pkg.sv */
package cmc_pkg;
  typedef enum logic [1:0] {
    CMC_ST_RUN,
    CMC_ST_WAIT_TX,
    CMC_ST_WAIT_IDLE
  } cmc_state_t;
endpackage

/* design/cmc_mode_control.sv */
`timescale 1ns/1ps
`include "cmc_defines.svh"
// Notes on behaviour
// - frames carry 11-bit base id, extended ones add an 18-bit id
// - a matching remote frame is answered with the data frame
// - overload frame on dominant in interframe space, at most two in a row
// - mode requested in bits 10:8, entered mode reported in bits 7:5
// - mode changes only after 11 consecutive recessive bits
// - configuration mode: no tx or rx, error counters cleared, flags kept
// - locked registers writable only in configuration mode
// - configuration mode waits for the running transmission to end
// - disable mode 001: no tx/rx, counters kept, wake flag, pins released
// - wake filter bit 14 low-pass filters rx input during sleep
// - disable during the 11-bit start wait aborts the pending transmission
// - mode 000 normal: drives tx pin and samples rx pin
// - listen-only 011: passive, tx pin released, no flags or acks
// - listen-all 111: errors ignored, partial messages stored
// - loopback 010: internal tx routed to rx, both pins released
// - 100 is configuration, 101 and 110 reserved, same report coding
// - request and reported fields reset to configuration mode
// - idle-stop bit 13 suspends operation during processor idle
// - abort-all bit 12 set by software, cleared when aborts complete
// - capture-link bit 3 gives a capture event per received message
// - bit 0 selects filter window or buffer window
// - data-bit compare count: 0 off, 17 max, above invalid
// - received messages are error checked then filtered before storing
module cmc_mode_control #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire logic              bit_tick,
  input  wire logic              bus_rx_pin,
  output logic                   bus_tx_pin,
  output logic                   bus_tx_oe,
  output logic                   rx_pin_owned,
  input  wire logic              eng_tx_bit,
  output logic                   eng_rx_bit,
  input  wire logic              eng_tx_busy,
  input  wire logic              eng_tx_pending,
  input  wire logic              eng_rx_done,
  input  wire logic              eng_rx_ok,
  input  wire logic              eng_filter_hit,
  input  wire logic              eng_rx_error,
  input  wire logic              eng_remote_match,
  input  wire logic              eng_ifs_dominant,
  input  wire logic              eng_rx_not_ready,
  input  wire logic              eng_all_aborted,
  input  wire logic              cpu_idle,
  input  wire logic              cpu_sleep,
  output logic                   tx_enable,
  output logic                   rx_enable,
  output logic                   send_error_ack,
  output logic                   err_count_clear,
  output logic                   err_count_hold,
  output logic                   ignore_errors,
  output logic                   store_message,
  output logic                   answer_remote,
  output logic                   overload_req,
  output logic                   abort_pending,
  output logic                   tx_aborted_flag,
  output logic                   tx_request_clear,
  output logic                   wake_flag_set,
  output logic                   capture_event,
  output logic                   window_select,
  output logic                   cfg_write_allow,
  output logic      [4:0]        data_bit_compare_count,
  output logic                   data_bit_compare_count_invalid
);

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  logic [2:0]            mode_request;
  logic [2:0]            mode_current;
  logic                  idle_stop;
  logic                  abort_all_tx;
  logic                  rx_capture_link;
  logic                  wake_lowpass_enable;
  logic [3:0]            idle_cnt;
  logic                  bus_idle;
  logic                  start_wait;
  logic                  mode_entry;
  logic [1:0]            ovl_cnt;
  logic [`CMC_WAKE_TAPS-1:0] wake_sr;
  logic                  rx_filt;
  logic                  rx_in;
  logic                  in_cfg;
  logic                  suspended;
  logic                  active;
  cmc_pkg::cmc_state_t   state;

  function automatic logic mode_valid(input logic [2:0] m);
    mode_valid = (m != `CMC_MODE_RSVD5) && (m != `CMC_MODE_RSVD6);
  endfunction

  function automatic logic mode_on_bus(input logic [2:0] m);
    mode_on_bus = (m == `CMC_MODE_NORMAL) || (m == `CMC_MODE_LISTEN) ||
                  (m == `CMC_MODE_ALL);
  endfunction

  assign in_cfg    = (mode_current == `CMC_MODE_CONFIG);
  assign suspended = idle_stop && cpu_idle;
  assign active    = !suspended && !in_cfg &&
                     (mode_current != `CMC_MODE_DISABLE);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // config lock
  assign cfg_write_allow = in_cfg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_request    <= `CMC_MODE_RESET;
      idle_stop       <= 1'b0;
      rx_capture_link <= 1'b0;
      window_select   <= 1'b0;
    end else if (reg_wr && reg_addr == `CMC_OFF_CTRL_ONE) begin
      mode_request  <= reg_wdata[`CMC_REQ_HI:`CMC_REQ_LO];
      window_select <= reg_wdata[`CMC_BIT_WINDOW];
      if (in_cfg) begin
        idle_stop       <= reg_wdata[`CMC_BIT_IDLE_STOP];
        rx_capture_link <= reg_wdata[`CMC_BIT_CAPTURE];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_lowpass_enable    <= 1'b0;
      data_bit_compare_count <= 5'h00;
    end else if (reg_wr && in_cfg) begin
      if (reg_addr == `CMC_OFF_CFG_TWO)
        wake_lowpass_enable <= reg_wdata[`CMC_BIT_WAKE_FILT];
      if (reg_addr == `CMC_OFF_DATA_BIT_COMPARE_COUNT_SET)
        data_bit_compare_count <= reg_wdata[4:0];
    end
  end

  assign data_bit_compare_count_invalid = (data_bit_compare_count > `CMC_DATA_BIT_COMPARE_COUNT_MAX);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      abort_all_tx <= 1'b0;
    end else if (reg_wr && reg_addr == `CMC_OFF_CTRL_ONE &&
                 reg_wdata[`CMC_BIT_ABORT]) begin
      abort_all_tx <= 1'b1;
    end else if (eng_all_aborted) begin
      abort_all_tx <= 1'b0;
    end
  end
  assign abort_pending = abort_all_tx;

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
      case (reg_addr)
        `CMC_OFF_CTRL_ONE: begin
          reg_rdata[`CMC_BIT_IDLE_STOP]        <= idle_stop;
          reg_rdata[`CMC_BIT_ABORT]            <= abort_all_tx;
          reg_rdata[`CMC_REQ_HI:`CMC_REQ_LO]   <= mode_request;
          reg_rdata[`CMC_CUR_HI:`CMC_CUR_LO]   <= mode_current;
          reg_rdata[`CMC_BIT_CAPTURE]          <= rx_capture_link;
          reg_rdata[`CMC_BIT_WINDOW]           <= window_select;
        end
        `CMC_OFF_CTRL_TWO: reg_rdata[4:0] <= data_bit_compare_count;
        `CMC_OFF_CFG_TWO:
          reg_rdata[`CMC_BIT_WAKE_FILT] <= wake_lowpass_enable;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // wake filter and bus idle
  // ----------------------------------------
  // low-pass during sleep
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_sr <= '1;
      rx_filt <= 1'b1;
    end else begin
      wake_sr <= {wake_sr[`CMC_WAKE_TAPS-2:0], bus_rx_pin};
      if (&wake_sr)
        rx_filt <= 1'b1;
      else if (~|wake_sr)
        rx_filt <= 1'b0;
    end
  end
  assign rx_in = (wake_lowpass_enable && cpu_sleep) ? rx_filt : bus_rx_pin;

  // wake on bus activity in disable mode
  assign wake_flag_set = (mode_current == `CMC_MODE_DISABLE) && !rx_in;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_cnt <= 4'h0;
    end else if (mode_entry) begin
      idle_cnt <= 4'h0;
    end else if (bit_tick) begin
      if (!rx_in)
        idle_cnt <= 4'h0;
      else if (idle_cnt != 4'(`CMC_IDLE_BITS))
        idle_cnt <= idle_cnt + 4'h1;
    end
  end
  assign bus_idle = (idle_cnt == 4'(`CMC_IDLE_BITS));
  assign mode_entry = (state == cmc_pkg::CMC_ST_WAIT_IDLE) && bus_idle &&
                      !eng_tx_busy && (mode_request != mode_current) &&
                      mode_valid(mode_request);

  // ----------------------------------------
  // mode sequencer
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= cmc_pkg::CMC_ST_RUN;
      mode_current <= `CMC_MODE_RESET;
    end else begin
      case (state)
        cmc_pkg::CMC_ST_RUN: begin
          if (mode_request != mode_current && mode_valid(mode_request))
            state <= cmc_pkg::CMC_ST_WAIT_TX;
        end
        cmc_pkg::CMC_ST_WAIT_TX: begin
          if (!eng_tx_busy || mode_request != `CMC_MODE_CONFIG)
            state <= cmc_pkg::CMC_ST_WAIT_IDLE;
        end
        cmc_pkg::CMC_ST_WAIT_IDLE: begin
          if (mode_request == mode_current || !mode_valid(mode_request)) begin
            state <= cmc_pkg::CMC_ST_RUN;
          end else if (mode_entry) begin
            mode_current <= mode_request;
            state        <= cmc_pkg::CMC_ST_RUN;
          end
        end
        default: state <= cmc_pkg::CMC_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_wait <= 1'b0;
    end else if (mode_entry) begin
      start_wait <= 1'b1;
    end else if (bus_idle) begin
      start_wait <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_aborted_flag  <= 1'b0;
      tx_request_clear <= 1'b0;
    end else begin
      tx_request_clear <= start_wait && eng_tx_pending &&
                          mode_request == `CMC_MODE_DISABLE;
      if (start_wait && eng_tx_pending &&
          mode_request == `CMC_MODE_DISABLE)
        tx_aborted_flag <= 1'b1;
      else if (eng_tx_pending)
        tx_aborted_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // per-mode controls
  always_comb begin
    tx_enable      = active && (mode_current == `CMC_MODE_NORMAL ||
                     mode_current == `CMC_MODE_LOOPBACK) && !start_wait;
    rx_enable      = active;
    send_error_ack = active && (mode_current == `CMC_MODE_NORMAL ||
                                mode_current == `CMC_MODE_LOOPBACK);
    ignore_errors  = (mode_current == `CMC_MODE_ALL);
    err_count_clear = in_cfg;
    err_count_hold  = !active || (mode_current == `CMC_MODE_LISTEN);
    rx_pin_owned    = active && (mode_current != `CMC_MODE_LOOPBACK);
    bus_tx_oe       = active && (mode_current == `CMC_MODE_NORMAL ||
                                 mode_current == `CMC_MODE_ALL);
    bus_tx_pin      = bus_tx_oe ? eng_tx_bit : 1'b1;
    eng_rx_bit = (mode_current == `CMC_MODE_LOOPBACK) ? eng_tx_bit : rx_in;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      store_message <= 1'b0;
      capture_event <= 1'b0;
      answer_remote <= 1'b0;
    end else begin
      store_message <= rx_enable && eng_rx_done &&
                       ((eng_rx_ok && eng_filter_hit) ||
                        (ignore_errors && eng_rx_error));
      capture_event <= rx_capture_link && rx_enable && eng_rx_done;
      answer_remote <= tx_enable && eng_remote_match;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovl_cnt      <= 2'h0;
      overload_req <= 1'b0;
    end else begin
      overload_req <= 1'b0;
      if (bus_idle || eng_rx_done) begin
        ovl_cnt <= 2'h0;
      end else if (send_error_ack && bit_tick &&
                   (eng_ifs_dominant || eng_rx_not_ready) &&
                   ovl_cnt < 2'(`CMC_MAX_OVERLOAD)) begin
        ovl_cnt      <= ovl_cnt + 2'h1;
        overload_req <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_mode_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode_current != $past(mode_current)) |-> $past(bus_idle))
    else $error("mode changed without idle bus");

  chk_cfg_tx: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode_current == `CMC_MODE_CONFIG && $past(mode_current) !=
     `CMC_MODE_CONFIG) |-> !$past(eng_tx_busy))
    else $error("config entered during transmission");

  chk_cfg_quiet: assert property (
    @(posedge clk) disable iff (sys_rst)
    in_cfg |-> (!tx_enable && !rx_enable && err_count_clear))
    else $error("config mode not quiet");

  chk_lock_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && !in_cfg && reg_addr == `CMC_OFF_CFG_TWO) |=>
    $stable(wake_lowpass_enable))
    else $error("locked register changed");

  chk_listen_tx: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode_current == `CMC_MODE_LISTEN) |-> (!bus_tx_oe && !send_error_ack))
    else $error("listen-only drove bus");

  chk_loop_route: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode_current == `CMC_MODE_LOOPBACK) |->
    (eng_rx_bit == eng_tx_bit && !bus_tx_oe && !rx_pin_owned))
    else $error("loopback routing wrong");

  chk_no_rsvd: assert property (
    @(posedge clk) disable iff (sys_rst)
    mode_valid(mode_current))
    else $error("reserved mode entered");

  chk_abort_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    (abort_all_tx && !eng_all_aborted) |=> abort_all_tx)
    else $error("abort bit dropped early");

  chk_capture_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    !$past(rx_capture_link) |-> !capture_event)
    else $error("capture without link bit");

  chk_overload_max: assert property (
    @(posedge clk) disable iff (sys_rst)
    ovl_cnt <= 2'(`CMC_MAX_OVERLOAD))
    else $error("too many overload frames");

endmodule

/* dv/cmc_can_node.sv */
`timescale 1ns/1ps
// ----------------------------------------
// far-side node: bit timing and wired bus
// ----------------------------------------
module cmc_can_node #(
  parameter int BIT_CLKS = 8
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic dom_req,
  input  wire logic bus_tx_pin,
  input  wire logic bus_tx_oe,
  output logic      bus_rx_pin,
  output logic      bit_tick
);
  logic [7:0] div_cnt;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt  <= 8'h00;
      bit_tick <= 1'h0;
    end else begin
      bit_tick <= (div_cnt == 8'(BIT_CLKS - 1));
      div_cnt  <= (div_cnt == 8'(BIT_CLKS - 1)) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // wired-and bus
  // a released driver leaves the line to the pull-up, i.e. recessive
  assign bus_rx_pin = !dom_req && !(bus_tx_oe && !bus_tx_pin);
endmodule

/* dv/cmc_mode_control_tb.sv */
`timescale 1ns/1ps
`include "cmc_defines.svh"
module cmc_mode_control_tb;
  typedef struct packed {
    logic [2:0] code;
    logic [2:0] cur;
    logic       oe;
    logic       ign;
  } cmc_row_t;

  logic        clk, sys_rst, reg_wr, reg_rd, bit_tick, bus_rx_pin;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic        bus_tx_pin, bus_tx_oe, rx_pin_owned, eng_tx_bit, eng_rx_bit;
  logic        eng_tx_busy, eng_tx_pending, eng_rx_done, eng_rx_ok;
  logic        eng_filter_hit, eng_rx_error, eng_remote_match;
  logic        eng_ifs_dominant, eng_rx_not_ready, eng_all_aborted;
  logic        cpu_idle, cpu_sleep, tx_enable, rx_enable, send_error_ack;
  logic        err_count_clear, err_count_hold, ignore_errors, store_message;
  logic        answer_remote, overload_req, abort_pending, tx_aborted_flag;
  logic        tx_request_clear, wake_flag_set, capture_event, window_select;
  logic        cfg_write_allow, data_bit_compare_count_invalid, node_dom;
  logic [4:0]  data_bit_compare_count;
  logic [2:0]  prev;
  int          error_cnt, check_count;
  cmc_row_t    rows [7];

  cmc_mode_control DUT (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bit_tick, .bus_rx_pin, .bus_tx_pin, .bus_tx_oe, .rx_pin_owned,
    .eng_tx_bit, .eng_rx_bit, .eng_tx_busy, .eng_tx_pending, .eng_rx_done,
    .eng_rx_ok, .eng_filter_hit, .eng_rx_error, .eng_remote_match,
    .eng_ifs_dominant, .eng_rx_not_ready, .eng_all_aborted, .cpu_idle,
    .cpu_sleep, .tx_enable, .rx_enable, .send_error_ack, .err_count_clear,
    .err_count_hold, .ignore_errors, .store_message, .answer_remote,
    .overload_req, .abort_pending, .tx_aborted_flag, .tx_request_clear,
    .wake_flag_set, .capture_event, .window_select, .cfg_write_allow,
    .data_bit_compare_count, .data_bit_compare_count_invalid
  );

  cmc_can_node #(.BIT_CLKS(8)) node (
    .clk, .sys_rst, .dom_req(node_dom), .bus_tx_pin, .bus_tx_oe,
    .bus_rx_pin, .bit_tick
  );

  always #2 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr    <= 1'h0;
    #1;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp,
                       input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd   <= 1'h0;
    #1;
    chk(reg_rdata, exp, what);
  endtask

  task automatic wait_ticks(input int n);
    int seen;
    int lim;
    seen = 0;
    lim = 0;
    while (seen < n && lim < 2000) begin
      @(posedge clk);
      if (bit_tick === 1'h1) seen++;
      lim++;
    end
    if (lim >= 2000) begin
      error_cnt++;
      $display("Error bit tick wait ran out");
      end_sim();
    end
  endtask

  task automatic mode_step(input logic [2:0] code, input logic [2:0] old_m,
                           input logic [2:0] new_m);
    logic [15:0] d;
    d = {5'h00, code, 8'h09};
    node_dom <= 1'h1;
    wait_ticks(1);
    node_dom <= 1'h0;
    wr(`CMC_OFF_CTRL_ONE, d);
    wait_ticks(10);
    rdchk(`CMC_OFF_CTRL_ONE, d | {8'h00, old_m, 5'h00}, "mode held");
    wait_ticks(3);
    rdchk(`CMC_OFF_CTRL_ONE, d | {8'h00, new_m, 5'h00}, "mode now");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    sys_rst = 1'h1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {eng_tx_busy, eng_tx_pending, eng_rx_done, eng_rx_ok} = '0;
    {eng_filter_hit, eng_rx_error, eng_remote_match} = '0;
    {eng_ifs_dominant, eng_rx_not_ready, eng_all_aborted} = '0;
    {cpu_idle, cpu_sleep, node_dom} = '0;
    eng_tx_bit = 1'h1;
    rows = '{'{3'h0, 3'h0, 1'h1, 1'h0}, '{3'h3, 3'h3, 1'h0, 1'h0},
             '{3'h7, 3'h7, 1'h1, 1'h1}, '{3'h2, 3'h2, 1'h0, 1'h0},
             '{3'h1, 3'h1, 1'h0, 1'h0}, '{3'h5, 3'h1, 1'h0, 1'h0},
             '{3'h4, 3'h4, 1'h0, 1'h0}};
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    rdchk(`CMC_OFF_CTRL_ONE, 16'h0480, "ctrl one reset");
    rdchk(`CMC_OFF_CTRL_TWO, 16'h0000, "ctrl two reset");
    rdchk(4'hF, 16'h0000, "unmapped read");
    wr(`CMC_OFF_CTRL_ONE, 16'h0409);
    rdchk(`CMC_OFF_CTRL_ONE, 16'h0489, "config write");
    chk({15'h0, window_select}, 16'h0001, "window select");
    wr(`CMC_OFF_DATA_BIT_COMPARE_COUNT_SET, 16'h0011);
    rdchk(`CMC_OFF_CTRL_TWO, 16'h0011, "compare count max");
    chk({15'h0, data_bit_compare_count_invalid}, 16'h0000, "count valid");
    wr(`CMC_OFF_DATA_BIT_COMPARE_COUNT_SET, 16'h0012);
    chk({15'h0, data_bit_compare_count_invalid}, 16'h0001, "count invalid");
    wr(`CMC_OFF_DATA_BIT_COMPARE_COUNT_SET, 16'h0000);
    rdchk(`CMC_OFF_CTRL_TWO, 16'h0000, "compare count off");
    wr(`CMC_OFF_CFG_TWO, 16'h4000);
    rdchk(`CMC_OFF_CFG_TWO, 16'h4000, "wake filter on");
    @(posedge clk);
    cpu_sleep <= 1'h1;
    node_dom  <= 1'h1;
    @(posedge clk);
    #1;
    chk({15'h0, eng_rx_bit}, 16'h0001, "wake glitch");
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0, eng_rx_bit}, 16'h0000, "wake level");
    node_dom  <= 1'h0;
    cpu_sleep <= 1'h0;
    wr(`CMC_OFF_CTRL_ONE, 16'h1409);
    rdchk(`CMC_OFF_CTRL_ONE, 16'h1489, "abort set");
    chk({15'h0, abort_pending}, 16'h0001, "abort pending");
    @(posedge clk);
    eng_all_aborted <= 1'h1;
    @(posedge clk);
    eng_all_aborted <= 1'h0;
    rdchk(`CMC_OFF_CTRL_ONE, 16'h0489, "abort cleared");
    $display("test registers done");
    prev = `CMC_MODE_CONFIG;
    foreach (rows[i]) begin
      mode_step(rows[i].code, prev, rows[i].cur);
      prev = rows[i].cur;
      chk({15'h0, bus_tx_oe}, {15'h0, rows[i].oe}, "tx drive");
      chk({15'h0, ignore_errors}, {15'h0, rows[i].ign}, "ignore");
      chk({15'h0, cfg_write_allow}, {15'h0, prev == 3'h4}, "lock");
      chk({15'h0, err_count_clear}, {15'h0, prev == 3'h4}, "clr");
      if (rows[i].code == `CMC_MODE_NORMAL) begin
        chk({15'h0, eng_rx_bit}, 16'h0001, "rx path");
        chk({15'h0, tx_enable}, 16'h0000, "start wait");
        wr(`CMC_OFF_CTRL_ONE, 16'h2001);
        rdchk(`CMC_OFF_CTRL_ONE, 16'h0009, "locked bits");
        wr(`CMC_OFF_CFG_TWO, 16'h0000);
        wr(`CMC_OFF_DATA_BIT_COMPARE_COUNT_SET, 16'h0005);
        rdchk(`CMC_OFF_CFG_TWO, 16'h4000, "cfg two locked");
        rdchk(`CMC_OFF_CTRL_TWO, 16'h0000, "count locked");
        wait_ticks(11);
        chk({15'h0, tx_enable}, 16'h0001, "start wait over");
        @(posedge clk);
        eng_rx_done      <= 1'h1;
        eng_rx_ok        <= 1'h1;
        eng_filter_hit   <= 1'h1;
        eng_remote_match <= 1'h1;
        @(posedge clk);
        eng_rx_done      <= 1'h0;
        eng_remote_match <= 1'h0;
        #1;
        chk({13'h0, capture_event, store_message, answer_remote}, 16'h0007,
            "rx events");
        node_dom <= 1'h1;
        wait_ticks(1);
        node_dom         <= 1'h0;
        eng_ifs_dominant <= 1'h1;
        wait_ticks(1);
        #1;
        chk({15'h0, overload_req}, 16'h0001, "overload");
        rd_val = 16'h0001;
        repeat (2) begin
          wait_ticks(1);
          #1;
          rd_val = rd_val + {15'h0, overload_req};
        end
        eng_ifs_dominant <= 1'h0;
        chk(rd_val, 16'h0002, "overload max");
        cpu_idle <= 1'h1;
        @(posedge clk);
        #1;
        chk({15'h0, rx_enable}, 16'h0001, "idle run");
        cpu_idle <= 1'h0;
      end
      if (rows[i].code == `CMC_MODE_DISABLE) begin
        chk({14'h0, tx_enable, rx_enable}, 16'h0000, "disable quiet");
        @(posedge clk);
        node_dom <= 1'h1;
        @(posedge clk);
        #1;
        chk({15'h0, wake_flag_set}, 16'h0001, "wake flag");
        node_dom <= 1'h0;
      end
      if (rows[i].code == `CMC_MODE_LOOPBACK) begin
        eng_tx_bit <= 1'h0;
        @(posedge clk);
        #1;
        chk({15'h0, eng_rx_bit}, 16'h0000, "loopback");
        chk({14'h0, bus_tx_pin, bus_tx_oe}, 16'h0002, "tx released");
        eng_tx_bit <= 1'h1;
      end
    end
    $display("test mode table done");
    mode_step(`CMC_MODE_NORMAL, `CMC_MODE_CONFIG, `CMC_MODE_NORMAL);
    eng_tx_pending <= 1'h1;
    wr(`CMC_OFF_CTRL_ONE, 16'h0109);
    @(posedge clk);
    #1;
    chk({14'h0, tx_aborted_flag, tx_request_clear}, 16'h0003, "abort");
    eng_tx_pending <= 1'h0;
    eng_tx_busy <= 1'h1;
    mode_step(`CMC_MODE_CONFIG, `CMC_MODE_NORMAL, `CMC_MODE_NORMAL);
    eng_tx_busy <= 1'h0;
    repeat (3) @(posedge clk);
    rdchk(`CMC_OFF_CTRL_ONE, 16'h0489, "config after tx");
    $display("test config wait done");
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    rdchk(`CMC_OFF_CTRL_ONE, 16'h0480, "second reset");
    rdchk(`CMC_OFF_CFG_TWO, 16'h0000, "cfg two reset");
    $display("test second reset done");
    end_sim();
  end
endmodule
